// ===== src/uia_pkg.sv
// Purpose: shared constants for the indirect register access port
// Assumes: 8-bit special function bus, 6-bit core register pointer
// Notes:   core register offsets are those of the function core map
package uia_pkg;
    // special function addresses
    localparam logic [7:0] UIA_SFR_SELECT = 8'h96;
    localparam logic [7:0] UIA_SFR_DATA   = 8'h97;
    // fields of the select register and endpoint selector widths
    localparam int         UIA_BUSY_BIT   = 7;
    localparam int         UIA_AUTO_BIT   = 6;
    localparam int         UIA_PTR_W      = 6;
    localparam int         UIA_ENDPOINT_SELECTOR_W    = 4;
    localparam int         UIA_EP_W       = 2;
    // reset values
    localparam logic [7:0] UIA_SELECT_RST = 8'h00;
    localparam logic [7:0] UIA_DATA_RST   = 8'h00;
    localparam logic [3:0] UIA_INDEX_RST  = 4'h0;
    // core register map
    localparam logic [5:0] UIA_FUNC_ADDR  = 6'h00;
    localparam logic [5:0] UIA_POWER      = 6'h01;
    localparam logic [5:0] UIA_IN_FLAGS   = 6'h02;
    localparam logic [5:0] UIA_OUT_FLAGS  = 6'h04;
    localparam logic [5:0] UIA_CMN_FLAGS  = 6'h06;
    localparam logic [5:0] UIA_IN_EN      = 6'h07;
    localparam logic [5:0] UIA_OUT_EN     = 6'h09;
    localparam logic [5:0] UIA_CMN_EN     = 6'h0b;
    localparam logic [5:0] UIA_FRAME_LO   = 6'h0c;
    localparam logic [5:0] UIA_FRAME_HI   = 6'h0d;
    localparam logic [5:0] UIA_EP_INDEX   = 6'h0e;
    localparam logic [5:0] UIA_CLK_REC    = 6'h0f;
    localparam logic [5:0] UIA_EP_ENABLE  = 6'h1e;
    localparam logic [5:0] UIA_FIFO_LO    = 6'h20;
    localparam logic [5:0] UIA_FIFO_HI    = 6'h22;
    // indexed endpoint registers
    localparam logic [5:0] UIA_IDX_CSR    = 6'h11;
    localparam logic [5:0] UIA_IDX_IN_HI  = 6'h12;
    localparam logic [5:0] UIA_IDX_OUT_LO = 6'h14;
    localparam logic [5:0] UIA_IDX_OUT_HI = 6'h15;
    localparam logic [5:0] UIA_IDX_CNT_LO = 6'h16;
    localparam logic [5:0] UIA_IDX_CNT_HI = 6'h17;
    // endpoint selector codes
    localparam logic [3:0] UIA_EP0        = 4'h0;
    localparam logic [3:0] UIA_EP_LAST    = 4'h2;
endpackage : uia_pkg

// ===== src/uia_sfr_if.sv
// Purpose: special function bus between processor core and access port
// Assumes: one clock shared by both ends, answer one cycle after read
// Notes:   no clocking block, the bench joins the two ends here
`timescale 1ns/100ps
`default_nettype none
interface uia_sfr_if;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic       sfr_we;
    logic       sfr_re;
    logic [7:0] sfr_rdata;

    // access port end
    modport dev (
        input  sfr_addr,
        input  sfr_wdata,
        input  sfr_we,
        input  sfr_re,
        output sfr_rdata
    );
    // processor end
    modport host (
        output sfr_addr,
        output sfr_wdata,
        output sfr_we,
        output sfr_re,
        input  sfr_rdata
    );
endinterface : uia_sfr_if
`default_nettype wire

// ===== src/uia_port.sv
// Purpose: indirect access port from special function bus to function core
// Assumes: core answers a read strobe with data on the following cycle
// Notes:   index register lives here, all other registers in the core
//          fetch: core strobe the cycle after start, capture the cycle after
//          that, so busy stands exactly two cycles
//          select writes during a fetch are dropped whole, so software polls first
//          unmapped or reserved targets read zero and swallow writes
`timescale 1ns/100ps
`default_nettype none
module uia_port (
    // clock and reset
    input  wire logic                      clock_i,
    input  wire logic                      rst_i,
    // special function bus
    uia_sfr_if.dev                         sfr,
    // function core register port
    output logic [uia_pkg::UIA_PTR_W-1:0]  core_addr_o,
    output logic [uia_pkg::UIA_EP_W-1:0]   core_ep_o,
    output logic                           core_rd_o,
    output logic                           core_wr_o,
    output logic [7:0]                     core_wdata_o,
    input  wire logic [7:0]                core_rdata_i,
    // status for the core side
    output logic [uia_pkg::UIA_ENDPOINT_SELECTOR_W-1:0] ep_select_o
);
    import uia_pkg::*;

    typedef enum logic [1:0] {
        UIA_IDLE,
        UIA_FETCH,
        UIA_CAPT
    } uia_fetch_t;

    // true when the pointer names a register of the core map
    function automatic logic uia_mapped(input logic [5:0] a, input logic [3:0] ep);
        logic common;
        logic indexed;
        // common registers ignore the selector
        common  = (a == UIA_FUNC_ADDR) || (a == UIA_POWER) ||
                  (a == UIA_IN_FLAGS) || (a == UIA_OUT_FLAGS) ||
                  (a == UIA_CMN_FLAGS) || (a == UIA_IN_EN) ||
                  (a == UIA_OUT_EN) || (a == UIA_CMN_EN) ||
                  (a == UIA_FRAME_LO) || (a == UIA_FRAME_HI) ||
                  (a == UIA_CLK_REC) || (a == UIA_EP_ENABLE) ||
                  ((a >= UIA_FIFO_LO) && (a <= UIA_FIFO_HI));
        // indexed registers follow the selector, high count has no endpoint 0 copy
        indexed = (a == UIA_IDX_CSR) || (a == UIA_IDX_IN_HI) ||
                  (a == UIA_IDX_OUT_LO) || (a == UIA_IDX_OUT_HI) ||
                  (a == UIA_IDX_CNT_LO) ||
                  ((a == UIA_IDX_CNT_HI) && (ep != UIA_EP0));
        // reserved selector codes reach no endpoint
        uia_mapped = common || (indexed && (ep <= UIA_EP_LAST));
    endfunction : uia_mapped

    // select register fields and data port
    logic [UIA_PTR_W-1:0]   ptr_q;
    logic                   auto_q;
    logic                   busy_q;
    logic [7:0]             data_q;
    logic [UIA_ENDPOINT_SELECTOR_W-1:0] index_q;
    logic [7:0]             rdata_q;
    logic [7:0]             wdata_q;
    logic                   wr_q;
    uia_fetch_t             state_q;
    uia_fetch_t             state_d;

    // sequencer phases, named once for the registers below
    wire logic idle_now  = (state_q == UIA_IDLE);
    wire logic fetch_now = (state_q == UIA_FETCH);
    wire logic capt_now  = (state_q == UIA_CAPT);

    // bus decode
    wire logic sel_hit   = (sfr.sfr_addr == UIA_SFR_SELECT);
    wire logic data_hit  = (sfr.sfr_addr == UIA_SFR_DATA);
    wire logic sel_wr    = sfr.sfr_we && sel_hit;
    wire logic data_wr   = sfr.sfr_we && data_hit;
    wire logic data_rd   = sfr.sfr_re && data_hit;
    // a fetch starts on busy written one or on a data read with auto set
    wire logic start_man = sel_wr && sfr.sfr_wdata[UIA_BUSY_BIT];
    wire logic start_aut = data_rd && auto_q;
    wire logic start_rd  = idle_now && !busy_q && (start_man || start_aut);
    // a pointer load during a fetch would retarget the strobe, so it is dropped
    wire logic sel_take  = sel_wr && !busy_q;
    // the index register is local, so its write never reaches the core
    wire logic idx_ptr   = (ptr_q == UIA_EP_INDEX);
    wire logic ptr_ok    = uia_mapped(ptr_q, index_q);
    // data writes while a fetch runs are dropped, software must poll first
    wire logic fwd_wr    = data_wr && !busy_q;
    // index and unmapped targets never go to the core
    wire logic core_wr_d = fwd_wr && !idx_ptr && ptr_ok;
    // read views of the local registers
    wire logic [7:0] idx_view = {4'h0, index_q};
    wire logic [7:0] sel_view = {busy_q, auto_q, ptr_q};
    wire logic [7:0] bus_view = sel_hit ? sel_view : (data_hit ? data_q : 8'h00);
    // value loaded into the data port at capture
    wire logic [7:0] fetch_val = idx_ptr ? idx_view : (ptr_ok ? core_rdata_i : 8'h00);

    // fetch sequencer: strobe the core, then capture one cycle later
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            UIA_IDLE:  if (start_rd) state_d = UIA_FETCH;
            UIA_FETCH: state_d = UIA_CAPT;
            UIA_CAPT:  state_d = UIA_IDLE;
            default:   state_d = UIA_IDLE;                            // spare code recovers
        endcase
    end

    // select register: pointer and auto flag
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ptr_q  <= UIA_SELECT_RST[UIA_PTR_W-1:0];
            auto_q <= UIA_SELECT_RST[UIA_AUTO_BIT];
        end else if (sel_take) begin
            ptr_q  <= sfr.sfr_wdata[UIA_PTR_W-1:0];
            auto_q <= sfr.sfr_wdata[UIA_AUTO_BIT];
        end
    end

    // busy stands from start until the data port is refilled
    always_ff @(posedge clock_i) begin
        if (rst_i)
            busy_q <= UIA_SELECT_RST[UIA_BUSY_BIT];
        else if (start_rd)
            busy_q <= 1'b1;
        else if (capt_now)
            busy_q <= 1'b0;
    end

    // sequencer state
    always_ff @(posedge clock_i) begin
        if (rst_i)
            state_q <= UIA_IDLE;
        else
            state_q <= state_d;
    end

    // data port: written by software, refilled by a fetch
    always_ff @(posedge clock_i) begin
        if (rst_i)
            data_q <= UIA_DATA_RST;
        else if (capt_now)
            data_q <= fetch_val;
        else if (fwd_wr)
            data_q <= sfr.sfr_wdata;
    end

    // endpoint index register, upper nibble not stored
    always_ff @(posedge clock_i) begin
        if (rst_i)
            index_q <= UIA_INDEX_RST;
        else if (fwd_wr && idx_ptr)
            index_q <= sfr.sfr_wdata[UIA_ENDPOINT_SELECTOR_W-1:0];
    end

    // core write strobe one cycle after the bus write
    always_ff @(posedge clock_i) begin
        if (rst_i)
            wr_q <= 1'b0;
        else
            wr_q <= core_wr_d;
    end

    // write data kept until the next forwarded write
    always_ff @(posedge clock_i) begin
        if (rst_i)
            wdata_q <= 8'h00;
        else if (fwd_wr)
            wdata_q <= sfr.sfr_wdata;
    end

    // registered read answer, one cycle after the strobe
    always_ff @(posedge clock_i) begin
        if (rst_i)
            rdata_q <= 8'h00;
        else if (sfr.sfr_re)
            rdata_q <= bus_view;
    end

    // core port, indexed accesses carry the selected endpoint
    assign core_addr_o   = ptr_q;
    assign core_ep_o     = index_q[UIA_EP_W-1:0];
    assign core_rd_o     = fetch_now && ptr_ok && !idx_ptr;
    assign core_wr_o     = wr_q;
    assign core_wdata_o  = wdata_q;
    assign ep_select_o   = index_q;
    // bus answer, registered so the host samples a settled value
    assign sfr.sfr_rdata = rdata_q;
endmodule : uia_port
`default_nettype wire

// ===== src/uia_cpu_end.sv
// Purpose: processor end that runs the indirect read and write procedures
// Assumes: bus answers a read one cycle after the strobe
// Notes:   remembers the last pointer so repeated accesses skip steps
`timescale 1ns/100ps
`default_nettype none
module uia_cpu_end (
    // clock and reset
    input  wire logic                      clock_i,
    input  wire logic                      rst_i,
    // command port
    input  wire logic                      cmd_valid_i,
    output logic                           cmd_ready_o,
    input  wire logic                      cmd_write_i,
    input  wire logic                      cmd_auto_i,
    input  wire logic [uia_pkg::UIA_PTR_W-1:0] cmd_ptr_i,
    input  wire logic [7:0]                cmd_wdata_i,
    // answer port
    output logic                           rsp_valid_o,
    output logic [7:0]                     rsp_data_o,
    // special function bus
    uia_sfr_if.host                        sfr
);
    import uia_pkg::*;

    typedef enum logic [2:0] {
        UIA_H_IDLE,
        UIA_H_POLL,
        UIA_H_CHK,
        UIA_H_LOAD,
        UIA_H_WRITE,
        UIA_H_READ,
        UIA_H_TAKE
    } uia_host_t;

    uia_host_t            state_q;
    logic                 write_q;
    logic                 auto_q;
    logic [UIA_PTR_W-1:0] ptr_q;
    logic [7:0]           wdata_q;
    logic                 second_q;
    logic [UIA_PTR_W-1:0] last_ptr_q;
    logic                 last_auto_q;
    logic                 known_q;
    logic                 armed_q;
    logic                 rsp_q;
    logic [7:0]           rsp_data_q;

    // skip decisions: same pointer, and a fetch already armed by auto
    wire logic same_sel  = known_q && (last_ptr_q == ptr_q) && (last_auto_q == auto_q);
    wire logic skip_read = same_sel && armed_q;
    wire logic busy_seen = sfr.sfr_rdata[UIA_BUSY_BIT];

    // procedure sequencer
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_q     <= UIA_H_IDLE;
            write_q     <= 1'b0;
            auto_q      <= 1'b0;
            ptr_q       <= '0;
            wdata_q     <= 8'h00;
            second_q    <= 1'b0;
            last_ptr_q  <= '0;
            last_auto_q <= 1'b0;
            known_q     <= 1'b0;
            armed_q     <= 1'b0;
            rsp_q       <= 1'b0;
            rsp_data_q  <= 8'h00;
        end else begin
            rsp_q <= 1'b0;
            unique case (state_q)
                UIA_H_IDLE: if (cmd_valid_i) begin
                    write_q  <= cmd_write_i;
                    auto_q   <= cmd_auto_i;
                    ptr_q    <= cmd_ptr_i;
                    wdata_q  <= cmd_wdata_i;
                    second_q <= 1'b0;
                    state_q  <= UIA_H_POLL;
                end
                UIA_H_POLL: state_q <= UIA_H_CHK;
                UIA_H_CHK: begin
                    if (busy_seen)
                        state_q <= UIA_H_POLL;
                    else if (second_q || (!write_q && skip_read))
                        state_q <= UIA_H_READ;
                    else if (write_q && same_sel)
                        state_q <= UIA_H_WRITE;
                    else
                        state_q <= UIA_H_LOAD;
                end
                UIA_H_LOAD: begin
                    last_ptr_q  <= ptr_q;
                    last_auto_q <= auto_q;
                    known_q     <= 1'b1;
                    second_q    <= 1'b1;
                    state_q     <= write_q ? UIA_H_WRITE : UIA_H_POLL;
                end
                UIA_H_WRITE: begin
                    armed_q <= 1'b0;
                    state_q <= UIA_H_IDLE;
                end
                UIA_H_READ: state_q <= UIA_H_TAKE;
                UIA_H_TAKE: begin
                    rsp_q      <= 1'b1;
                    rsp_data_q <= sfr.sfr_rdata;
                    armed_q    <= auto_q;
                    state_q    <= UIA_H_IDLE;
                end
                default: state_q <= UIA_H_IDLE;
            endcase
        end
    end

    // bus drive per state
    wire logic poll_rd = (state_q == UIA_H_POLL);
    wire logic data_rd = (state_q == UIA_H_READ);
    wire logic load_wr = (state_q == UIA_H_LOAD);
    wire logic data_wr = (state_q == UIA_H_WRITE);

    assign sfr.sfr_re    = poll_rd || data_rd;
    assign sfr.sfr_we    = load_wr || data_wr;
    assign sfr.sfr_addr  = (poll_rd || load_wr) ? UIA_SFR_SELECT : UIA_SFR_DATA;
    assign sfr.sfr_wdata = load_wr ? {!write_q, auto_q, ptr_q} : wdata_q;
    assign cmd_ready_o   = (state_q == UIA_H_IDLE);
    assign rsp_valid_o   = rsp_q;
    assign rsp_data_o    = rsp_data_q;
endmodule : uia_cpu_end
`default_nettype wire

// ===== tb/uia_checker_properties.sv
// Purpose: timing checks on the bus between the two ends and the core port
// Assumes: one clock, synchronous active high reset
// Notes:   busy is seen only through select register reads
`timescale 1ns/100ps
`default_nettype none
module uia_checker_properties (
    // clock and reset
    input wire logic       clock_i,
    input wire logic       rst_i,
    // special function bus
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       sfr_we,
    input wire logic       sfr_re,
    input wire logic [7:0] sfr_rdata,
    // core port
    input wire logic [5:0] core_addr_o,
    input wire logic       core_rd_o,
    input wire logic       core_wr_o,
    input wire logic [7:0] core_wdata_o,
    input wire logic [3:0] ep_select_o
);
    import uia_pkg::*;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // decoded bus events
    wire logic data_wr = sfr_we && (sfr_addr == UIA_SFR_DATA);
    wire logic data_rd = sfr_re && (sfr_addr == UIA_SFR_DATA);
    wire logic sel_wr  = sfr_we && (sfr_addr == UIA_SFR_SELECT);
    wire logic sel_rd  = sfr_re && (sfr_addr == UIA_SFR_SELECT) && !sfr_we;

    property p_wr_fwd;
        core_wr_o |-> $past(data_wr) && (core_wdata_o == $past(sfr_wdata));
    endproperty
    a_wr_fwd: assert property (p_wr_fwd)
        else $error("core write without matching data port write");
    property p_idx_local;
        (core_wr_o || core_rd_o) |-> (core_addr_o != UIA_EP_INDEX);
    endproperty
    a_idx_local: assert property (p_idx_local)
        else $error("index register access forwarded to core");
    property p_rd_cause;
        core_rd_o |-> $past(sel_wr && sfr_wdata[UIA_BUSY_BIT]) || $past(data_rd);
    endproperty
    a_rd_cause: assert property (p_rd_cause)
        else $error("core fetch without busy set or auto read");
    property p_rd_space;
        core_rd_o |=> !core_rd_o [*2];
    endproperty
    a_rd_space: assert property (p_rd_space)
        else $error("core fetches too close");
    property p_busy_seen;
        (sel_rd && core_rd_o) |=> sfr_rdata[UIA_BUSY_BIT];
    endproperty
    a_busy_seen: assert property (p_busy_seen)
        else $error("busy low while fetching");
    property p_busy_clear;
        core_rd_o ##2 sel_rd |=> !sfr_rdata[UIA_BUSY_BIT];
    endproperty
    a_busy_clear: assert property (p_busy_clear)
        else $error("busy still high after fetch");
    property p_rdata_hold;
        !sfr_re |=> $stable(sfr_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read answer changed without a read");
    property p_idx_upd;
        !$past(rst_i) && (ep_select_o != $past(ep_select_o)) |->
            $past(data_wr) && (ep_select_o == $past(sfr_wdata[3:0]));
    endproperty
    a_idx_upd: assert property (p_idx_upd)
        else $error("endpoint selector changed wrongly");
    property p_auto_ptr;
        (core_rd_o && $past(data_rd)) |-> $stable(core_addr_o);
    endproperty
    a_auto_ptr: assert property (p_auto_ptr)
        else $error("auto read moved the pointer");
endmodule : uia_checker_properties
`default_nettype wire

// ===== tb/tb_usb_indirect_register_access.sv
// Purpose: joins processor end and access port, checks reads against writes
// Assumes: core stand-in answers one cycle after its read strobe
// Notes:   common registers ignore the endpoint, indexed ones keep one copy each
`timescale 1ns/100ps
`default_nettype none
module tb_usb_indirect_register_access;
    import uia_pkg::*;
    logic        clock_i     = 1'b0;
    logic        rst_i       = 1'b1;
    logic        cmd_valid   = 1'b0;
    logic        cmd_write   = 1'b0;
    logic        cmd_auto    = 1'b0;
    logic [5:0]  cmd_ptr     = 6'h00;
    logic [7:0]  cmd_wdata   = 8'h00;
    logic [7:0]  core_rdata  = 8'h00;
    logic        cmd_ready;
    logic        rsp_valid;
    logic [7:0]  rsp_data;
    logic [5:0]  core_addr;
    logic [1:0]  core_ep;
    logic        core_rd;
    logic        core_wr;
    logic [7:0]  core_wdata;
    logic [3:0]  ep_select;
    logic [7:0]  mem [256];
    logic [7:0]  ref_mem [256];
    logic [3:0]  idx         = 4'h0;
    logic [31:0] seed        = 32'hcce2;
    int          err_total   = 0;
    int          checks_done = 0;

    always #20 clock_i = ~clock_i;

    uia_sfr_if sfr_bus ();
    uia_port i_uia_port (.clock_i(clock_i), .rst_i(rst_i), .sfr(sfr_bus.dev), .core_addr_o(core_addr),
        .core_ep_o(core_ep), .core_rd_o(core_rd), .core_wr_o(core_wr), .core_wdata_o(core_wdata),
        .core_rdata_i(core_rdata), .ep_select_o(ep_select));
    uia_cpu_end i_uia_cpu_end (.clock_i(clock_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid),
        .cmd_ready_o(cmd_ready), .cmd_write_i(cmd_write), .cmd_auto_i(cmd_auto), .cmd_ptr_i(cmd_ptr),
        .cmd_wdata_i(cmd_wdata), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .sfr(sfr_bus.host));
    uia_checker_properties i_uia_checker_properties (.clock_i(clock_i), .rst_i(rst_i),
        .sfr_addr(sfr_bus.sfr_addr), .sfr_wdata(sfr_bus.sfr_wdata), .sfr_we(sfr_bus.sfr_we),
        .sfr_re(sfr_bus.sfr_re), .sfr_rdata(sfr_bus.sfr_rdata), .core_addr_o(core_addr),
        .core_rd_o(core_rd), .core_wr_o(core_wr), .core_wdata_o(core_wdata), .ep_select_o(ep_select));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    function automatic logic is_idx(logic [5:0] p);
        return p inside {6'h11, 6'h12, 6'h14, 6'h15, 6'h16, 6'h17};
    endfunction : is_idx
    // reserved selectors on indexed registers and 0x17 on endpoint 0 behave as unmapped
    function automatic logic mapped(logic [5:0] p, logic [3:0] e);
        if (is_idx(p))
            return (e <= UIA_EP_LAST) && !(p == UIA_IDX_CNT_HI && e == UIA_EP0);
        return p inside {6'h00, 6'h01, 6'h02, 6'h04, 6'h06, 6'h07, 6'h09, 6'h0b,
                         6'h0c, 6'h0d, 6'h0f, 6'h1e, 6'h20, 6'h21, 6'h22};
    endfunction : mapped
    function automatic logic [7:0] key(logic [5:0] p, logic [1:0] e);
        return is_idx(p) ? {e, p} : {2'b00, p};
    endfunction : key

    // core stand-in: stale answer is inverted so a late sample shows
    always @(posedge clock_i) begin
        if (core_wr)
            mem[key(core_addr, core_ep)] <= core_wdata;
        core_rdata <= core_rd ? mem[key(core_addr, core_ep)] : ~core_rdata;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic final_report();
        if (err_total == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    // one command through the processor end, read answers compared
    task automatic op(input logic w, input logic a, input logic [5:0] p, input logic [7:0] d);
        logic [7:0] exp;
        int         n;
        exp = (p == UIA_EP_INDEX) ? {4'h0, idx} : (mapped(p, idx) ? ref_mem[key(p, idx[1:0])] : 8'h00);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_auto  <= a;
        cmd_ptr   <= p;
        cmd_wdata <= d;
        do @(posedge clock_i); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while ((w ? cmd_ready !== 1'b1 : rsp_valid !== 1'b1) && n < 200);
        check("op_done", {7'h00, n < 200}, 8'h01);
        if (w) begin
            if (p == UIA_EP_INDEX)
                idx = d[3:0];
            else if (mapped(p, idx))
                ref_mem[key(p, idx[1:0])] = d;
            check("ep_select", {4'h0, ep_select}, {4'h0, idx});
        end else
            check("read", rsp_data, exp);
    endtask : op

    // watchdog, far beyond the few thousand cycles the tests need
    initial begin
        repeat (40000) @(posedge clock_i);
        err_total++;
        final_report();
    end

    initial begin
        logic [31:0] r;
        for (int i = 0; i < 256; i++) begin
            r = xs();
            mem[i] = r[7:0];
            ref_mem[i] = r[7:0];
        end
        repeat (6) @(posedge clock_i);
        rst_i <= 1'b0;
        op(1'b0, 1'b0, UIA_EP_INDEX, 8'h00);
        op(1'b1, 1'b0, UIA_EP_INDEX, 8'hf2);
        op(1'b0, 1'b0, UIA_EP_INDEX, 8'h00);
        // pointers 0 to 35 except the index, for endpoint codes 0 to 3, one reserved among them
        for (int e = 0; e < 4; e++) begin
            op(1'b1, 1'b0, UIA_EP_INDEX, 8'(e));
            for (int p = 0; p < 36; p++) begin
                r = xs();
                if (p != 14) begin
                    op(1'b1, 1'b0, 6'(p), r[7:0]);
                    op(1'b1, 1'b0, 6'(p), r[15:8]);
                    op(1'b0, r[16], 6'(p), 8'h00);
                end
            end
        end
        // repeated reads with auto read on endpoint 1, pointer and busy set skipped
        op(1'b1, 1'b0, UIA_EP_INDEX, 8'h01);
        repeat (3) op(1'b0, 1'b1, UIA_IDX_CSR, 8'h00);
        // a write in between must not leave the auto fetched byte behind
        op(1'b1, 1'b1, UIA_IDX_CSR, 8'h5a);
        repeat (2) op(1'b0, 1'b1, UIA_IDX_CSR, 8'h00);
        repeat (120) begin
            r = xs();
            op(r[0], r[1], r[13:8], r[23:16]);
        end
        // mid-run reset puts the selector back on endpoint 0
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        idx = 4'h0;
        op(1'b0, 1'b0, UIA_EP_INDEX, 8'h00);
        final_report();
    end
endmodule : tb_usb_indirect_register_access
`default_nettype wire
